/* File: rtl/qec_quadrature_encoder_control.sv */
`include "qec_map.svh"
`default_nettype none

// Summary of operation
// [RL1] Counter enable clear stops counters, registers live
// [RL2] Stop-in-idle halts operation during device idle
// [RL3] Init mode: none, clear, load next, modulo
// [RL4] Home then first or second index loads
// [RL5] Mode 101 clears position at greater compare
// [RL6] Timer count modes ignore init mode
// [RL7] Quadrature mode: index match clears position
// [RL8] Index match uses swapped, polarity-adjusted phases
// [RL9] Prescaler divides timer clock by power two
// [RL10] Direction bit negates count; in external updown too
// [RL11] Gate enable lets gate pin stall position
// [RL12] Count mode: x4, updown, gated, timer
// [RL13] Capture enable captures position on index match
// [RL14] Filter enable filters four inputs, else bypass
// [RL15] Filter clock divide by power of two
// [RL16] Compare pin function: off, ge, le, window
// [RL17] Swap exchanges phases before the decoder
// [RL18] Polarity bits invert each encoder input
// [RL19] Status bits show conditioned input levels
// [RL20] Compare flags set while position meets compares
// [RL21] Overflow flags set on counter wrap
// [RL22] Home, index, homing-complete flags set by events
// [RL23] Interrupt while any flag and enable set
module qec_quadrature_encoder_control
    import qec_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire qec_avs_req_type i_avs,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire qec_pins_type i_enc,
    input wire logic i_ext_gate,
    input wire logic i_idle_mode,
    output logic o_compare_output_pin,
    output logic o_irq
);

    qec_state_type r_r;
    qec_state_type r_nxt;

    logic run;
    logic timer_mode;
    logic pa, pb, pidx, phome;
    logic qa, qb;
    logic match;
    logic idx_rise, idx_ev, home_ev;
    logic ptick, ftick;
    logic cnt_ev, up, gate_ok;
    logic ge_cond, le_cond;
    logic wr_go, acc;
    logic [15:0] ctrl_w, ioc_w, stat_w;
    qec_stat_type set_s;
    logic [4:0] raw;

    function automatic logic div_tick(input logic [6:0] cnt, input logic [2:0] sel);
        logic [6:0] m;
        m = 7'((8'h01 << sel) - 8'h01);
        return (cnt & m) == m;
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old, input qec_avs_req_type q);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (q.byteenable[i]) begin
                v[i*8 +: 8] = q.writedata[i*8 +: 8];
            end
        end
        return v;
    endfunction

    function automatic logic hit(input qec_avs_req_type q, input logic [7:0] ofs);
        return q.address == ofs;
    endfunction

    assign raw = {i_ext_gate, i_enc};

    always_comb begin
        r_nxt = r_r;
        set_s = '0;

        // Pins pass three flops; a new level counts once the last two agree.
        r_nxt.sync1 = raw;
        r_nxt.sync2 = r_r.sync1;
        r_nxt.sync3 = r_r.sync2;
        r_nxt.stable = ((r_r.sync2 ~^ r_r.sync3) & r_r.sync3) |
                       ((r_r.sync2 ^ r_r.sync3) & r_r.stable);

        // The filter demands three equal samples on the divided filter clock.
        r_nxt.filter_div = r_r.filter_div + 7'h01;
        ftick = div_tick(r_r.filter_div, r_r.ioc.filter_clock_divide); // [RL15]
        for (int i = 0; i < 4; i++) begin
            if (!r_r.ioc.input_filter_enable) begin
                r_nxt.filter_val[i] = r_r.stable[i]; // [RL14]
                r_nxt.filter_cnt[i] = 2'h0;
            end else if (ftick) begin
                if (r_r.stable[i] == r_r.filter_val[i]) begin
                    r_nxt.filter_cnt[i] = 2'h0;
                end else if (r_r.filter_cnt[i] == `QEC_FILTER_SAMPLES - 2'h1) begin
                    r_nxt.filter_val[i] = r_r.stable[i]; // [RL14]
                    r_nxt.filter_cnt[i] = 2'h0;
                end else begin
                    r_nxt.filter_cnt[i] = r_r.filter_cnt[i] + 2'h1;
                end
            end
        end

        pa = r_r.filter_val[0] ^ r_r.ioc.phase_a_polarity; // [RL18]
        pb = r_r.filter_val[1] ^ r_r.ioc.phase_b_polarity; // [RL18]
        pidx = r_r.filter_val[2] ^ r_r.ioc.index_polarity; // [RL18]
        phome = r_r.filter_val[3] ^ r_r.ioc.home_polarity; // [RL18]
        qa = r_r.ioc.phase_swap ? pb : pa; // [RL17]
        qb = r_r.ioc.phase_swap ? pa : pb; // [RL17]
        r_nxt.ioc.home_status = phome; // [RL19]
        r_nxt.ioc.index_status = pidx; // [RL19]
        r_nxt.ioc.phase_b_status = qb; // [RL19]
        r_nxt.ioc.phase_a_status = qa; // [RL19]
        r_nxt.prev_a = qa;
        r_nxt.prev_b = qb;
        r_nxt.prev_index = pidx;
        r_nxt.prev_home = phome;

        run = r_r.ctrl.counter_enable_bit && // [RL1]
              !(r_r.ctrl.stop_in_idle_bit && i_idle_mode); // [RL2]
        timer_mode = r_r.ctrl.count_mode_select[1]; // [RL6]

        // The index only counts in quadrature mode when the phases match.
        match = (qb == r_r.ctrl.index_match_value[1]) && // [RL8]
                (qa == r_r.ctrl.index_match_value[0]);
        idx_rise = pidx && !r_r.prev_index;
        idx_ev = idx_rise && (r_r.ctrl.count_mode_select != QEC_CCM_QUAD || match); // [RL7]
        home_ev = phome && !r_r.prev_home;

        if (run) begin
            r_nxt.presc_div = r_r.presc_div + 7'h01;
        end
        ptick = run && div_tick(r_r.presc_div, r_r.ctrl.timer_prescale_select); // [RL9]
        gate_ok = !r_r.ctrl.gate_enable || r_r.stable[4]; // [RL11]

        unique case (r_r.ctrl.count_mode_select) // [RL12]
            QEC_CCM_QUAD: begin
                cnt_ev = (qa ^ r_r.prev_a) ^ (qb ^ r_r.prev_b);
                up = qa ^ r_r.prev_b;
            end
            QEC_CCM_EXT_UPDN: begin
                cnt_ev = qa && !r_r.prev_a;
                up = qb; // [RL10]
            end
            QEC_CCM_EXT_GATED: begin
                cnt_ev = qa && !r_r.prev_a;
                up = 1'b1;
            end
            QEC_CCM_INT_TIMER: begin
                cnt_ev = ptick;
                up = 1'b1;
            end
        endcase
        up = up ^ r_r.ctrl.count_direction_select; // [RL10]

        if (run && cnt_ev && gate_ok) begin // [RL1] [RL11]
            if (!timer_mode && r_r.ctrl.position_init_mode == QEC_PI_MODULO && // [RL3]
                up && r_r.position_counter == r_r.greater_compare_value) begin
                r_nxt.position_counter = r_r.lesser_compare_value;
            end else if (!timer_mode && r_r.ctrl.position_init_mode == QEC_PI_MODULO &&
                         !up && r_r.position_counter == r_r.lesser_compare_value) begin
                r_nxt.position_counter = r_r.greater_compare_value; // [RL3]
            end else begin
                r_nxt.position_counter = up ? r_r.position_counter + 32'h1 :
                                              r_r.position_counter - 32'h1;
                set_s.position_overflow_flag = up ? &r_r.position_counter : // [RL21]
                                                    ~|r_r.position_counter;
            end
            r_nxt.velocity = up ? r_r.velocity + 16'h1 : r_r.velocity - 16'h1;
            set_s.velocity_overflow_flag = up ? r_r.velocity == 16'h7FFF : // [RL21]
                                                r_r.velocity == 16'h8000;
        end
        if (ptick) begin
            r_nxt.interval_timer = r_r.interval_timer + 32'h1;
        end

        if (run) begin
            if (idx_ev) begin
                r_nxt.index_count = up ? r_r.index_count + 32'h1 : r_r.index_count - 32'h1;
                set_s.index_event_flag = 1'b1; // [RL22]
                if (r_r.ioc.index_capture_enable) begin
                    r_nxt.init_capture_value = r_r.position_counter; // [RL13]
                end
            end
            if (home_ev) begin
                set_s.home_event_flag = 1'b1; // [RL22]
            end
            if (!timer_mode) begin // [RL6]
                unique case (r_r.ctrl.position_init_mode)
                    QEC_PI_CLR_IDX: begin
                        if (idx_ev) begin
                            r_nxt.position_counter = 32'h0; // [RL3] [RL7]
                        end
                    end
                    QEC_PI_LOAD_NEXT: begin
                        if (idx_ev && r_r.load_armed) begin
                            r_nxt.position_counter = r_r.init_capture_value; // [RL3]
                            r_nxt.load_armed = 1'b0;
                        end
                    end
                    QEC_PI_HOME_FIRST, QEC_PI_HOME_SECOND: begin
                        if (home_ev) begin
                            r_nxt.home_seen = 1'b1;
                            r_nxt.index_once = 1'b0;
                        end else if (idx_ev && r_r.home_seen) begin
                            if (r_r.ctrl.position_init_mode == QEC_PI_HOME_FIRST ||
                                r_r.index_once) begin
                                r_nxt.position_counter = r_r.init_capture_value; // [RL4]
                                set_s.homing_complete_flag = 1'b1; // [RL4] [RL22]
                                r_nxt.home_seen = 1'b0;
                                r_nxt.index_once = 1'b0;
                            end else begin
                                r_nxt.index_once = 1'b1; // [RL4]
                            end
                        end
                    end
                    QEC_PI_CLR_GE: begin
                        if (r_r.position_counter == r_r.greater_compare_value) begin
                            r_nxt.position_counter = 32'h0; // [RL5]
                        end
                    end
                    QEC_PI_NONE, QEC_PI_MODULO, QEC_PI_RSVD: begin
                    end
                endcase
            end
        end

        ge_cond = $signed(r_r.position_counter) >= $signed(r_r.greater_compare_value);
        le_cond = $signed(r_r.position_counter) <= $signed(r_r.lesser_compare_value);
        set_s.greater_equal_flag = ge_cond; // [RL20]
        set_s.less_equal_flag = le_cond; // [RL20]
        unique case (r_r.ioc.compare_output_function) // [RL16]
            2'h0: r_nxt.compare_pin = 1'b0;
            2'h1: r_nxt.compare_pin = ge_cond;
            2'h2: r_nxt.compare_pin = le_cond;
            2'h3: r_nxt.compare_pin = ge_cond && le_cond;
        endcase

        // One wait cycle per access; the write lands when waitrequest is low.
        acc = (i_avs.read || i_avs.write) && !r_r.ack;
        wr_go = i_avs.write && r_r.ack;
        r_nxt.ack = acc;
        ctrl_w = 16'(be_merge({16'h0000, r_r.ctrl}, i_avs));
        ioc_w = 16'(be_merge({16'h0000, r_r.ioc}, i_avs));
        stat_w = 16'(be_merge({16'h0000, r_r.stat}, i_avs));
        if (acc) begin
            unique case (i_avs.address)
                `QEC_OFS_CTRL: r_nxt.rdata = {16'h0000, r_r.ctrl};
                `QEC_OFS_IOC: r_nxt.rdata = {16'h0000, r_r.ioc};
                `QEC_OFS_STAT: r_nxt.rdata = {16'h0000, r_r.stat};
                `QEC_OFS_POS: r_nxt.rdata = r_r.position_counter;
                `QEC_OFS_INIT_CAP: r_nxt.rdata = r_r.init_capture_value;
                `QEC_OFS_GT_CMP: r_nxt.rdata = r_r.greater_compare_value;
                `QEC_OFS_LT_CMP: r_nxt.rdata = r_r.lesser_compare_value;
                `QEC_OFS_VEL: r_nxt.rdata = {16'h0000, r_r.velocity};
                `QEC_OFS_IDX_CNT: r_nxt.rdata = r_r.index_count;
                `QEC_OFS_INT_TMR: r_nxt.rdata = r_r.interval_timer;
                default: r_nxt.rdata = 32'h0;
            endcase
        end
        if (wr_go) begin // [RL1]
            if (hit(i_avs, `QEC_OFS_CTRL)) begin
                r_nxt.ctrl = ctrl_w & `QEC_CTRL_WMASK;
                r_nxt.load_armed = ctrl_w[12:10] == QEC_PI_LOAD_NEXT;
                r_nxt.home_seen = 1'b0;
                r_nxt.index_once = 1'b0;
            end
            if (hit(i_avs, `QEC_OFS_IOC)) begin
                r_nxt.ioc = (ioc_w & `QEC_IOC_WMASK) | (r_nxt.ioc & ~`QEC_IOC_WMASK);
            end
            if (hit(i_avs, `QEC_OFS_POS)) begin
                r_nxt.position_counter = be_merge(r_r.position_counter, i_avs);
            end
            if (hit(i_avs, `QEC_OFS_INIT_CAP)) begin
                r_nxt.init_capture_value = be_merge(r_r.init_capture_value, i_avs);
            end
            if (hit(i_avs, `QEC_OFS_GT_CMP)) begin
                r_nxt.greater_compare_value = be_merge(r_r.greater_compare_value, i_avs);
            end
            if (hit(i_avs, `QEC_OFS_LT_CMP)) begin
                r_nxt.lesser_compare_value = be_merge(r_r.lesser_compare_value, i_avs);
            end
            if (hit(i_avs, `QEC_OFS_VEL)) begin
                r_nxt.velocity = 16'(be_merge({16'h0000, r_r.velocity}, i_avs));
            end
            if (hit(i_avs, `QEC_OFS_IDX_CNT)) begin
                r_nxt.index_count = be_merge(r_r.index_count, i_avs);
            end
            if (hit(i_avs, `QEC_OFS_INT_TMR)) begin
                r_nxt.interval_timer = be_merge(r_r.interval_timer, i_avs);
            end
        end

        // Writing 0 clears a flag, writing 1 leaves it; a new event beats the clear.
        if (wr_go && hit(i_avs, `QEC_OFS_STAT)) begin
            r_nxt.stat = (stat_w & `QEC_STAT_EN_MASK) |
                         (stat_w & r_r.stat & `QEC_STAT_FLAG_MASK) | set_s; // [RL21] [RL22]
        end else begin
            r_nxt.stat = r_r.stat | set_s; // [RL20] [RL21] [RL22]
        end

        r_nxt.irq = |({r_r.stat[13], r_r.stat[11], r_r.stat[9], r_r.stat[7], // [RL23]
                       r_r.stat[5], r_r.stat[3], r_r.stat[1]} &
                      {r_r.stat[12], r_r.stat[10], r_r.stat[8], r_r.stat[6],
                       r_r.stat[4], r_r.stat[2], r_r.stat[0]});
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign o_avs_readdata = r_r.rdata;
    assign o_avs_waitrequest = !r_r.ack;
    assign o_compare_output_pin = r_r.compare_pin;
    assign o_irq = r_r.irq;

endmodule

`default_nettype wire

/* File: rtl/qec_map.svh */
`ifndef QEC_MAP_SVH
`define QEC_MAP_SVH

// Byte addresses of the register words on the Avalon-MM slave.
`define QEC_OFS_CTRL 8'h00
`define QEC_OFS_IOC 8'h04
`define QEC_OFS_STAT 8'h08
`define QEC_OFS_POS 8'h0C
`define QEC_OFS_INIT_CAP 8'h10
`define QEC_OFS_GT_CMP 8'h14
`define QEC_OFS_LT_CMP 8'h18
`define QEC_OFS_VEL 8'h1C
`define QEC_OFS_IDX_CNT 8'h20
`define QEC_OFS_INT_TMR 8'h24

// Writable bits of the 16-bit control words; the rest read as stored or live.
`define QEC_CTRL_WMASK 16'hBF7F
`define QEC_IOC_WMASK 16'hFFF0
`define QEC_STAT_FLAG_MASK 16'h2AAA
`define QEC_STAT_EN_MASK 16'h1555

// Reset values.
`define QEC_CTRL_RESET 16'h0000
`define QEC_IOC_RESET 16'h0000
`define QEC_STAT_RESET 16'h0000

// Filter needs this many equal samples in a row before it accepts a new level.
`define QEC_FILTER_SAMPLES 2'h3

`endif

/* File: rtl/qec_pkg.sv */
`default_nettype none

package qec_pkg;

    typedef enum logic [1:0] {
        QEC_CCM_QUAD = 2'h0,
        QEC_CCM_EXT_UPDN = 2'h1,
        QEC_CCM_EXT_GATED = 2'h2,
        QEC_CCM_INT_TIMER = 2'h3
    } qec_ccm_type;

    typedef enum logic [2:0] {
        QEC_PI_NONE = 3'h0,
        QEC_PI_CLR_IDX = 3'h1,
        QEC_PI_LOAD_NEXT = 3'h2,
        QEC_PI_HOME_FIRST = 3'h3,
        QEC_PI_HOME_SECOND = 3'h4,
        QEC_PI_CLR_GE = 3'h5,
        QEC_PI_MODULO = 3'h6,
        QEC_PI_RSVD = 3'h7
    } qec_position_init_mode_type;

    typedef struct packed {
        logic counter_enable_bit;
        logic rsvd14;
        logic stop_in_idle_bit;
        qec_position_init_mode_type position_init_mode;
        logic [1:0] index_match_value;
        logic rsvd7;
        logic [2:0] timer_prescale_select;
        logic count_direction_select;
        logic gate_enable;
        qec_ccm_type count_mode_select;
    } qec_ctrl_type;

    typedef struct packed {
        logic index_capture_enable;
        logic input_filter_enable;
        logic [2:0] filter_clock_divide;
        logic [1:0] compare_output_function;
        logic phase_swap;
        logic home_polarity;
        logic index_polarity;
        logic phase_b_polarity;
        logic phase_a_polarity;
        logic home_status;
        logic index_status;
        logic phase_b_status;
        logic phase_a_status;
    } qec_ioc_type;

    typedef struct packed {
        logic [1:0] rsvd;
        logic greater_equal_flag;
        logic greater_equal_irq_enable;
        logic less_equal_flag;
        logic less_equal_irq_enable;
        logic position_overflow_flag;
        logic position_overflow_irq_enable;
        logic homing_complete_flag;
        logic homing_complete_irq_enable;
        logic velocity_overflow_flag;
        logic velocity_overflow_irq_enable;
        logic home_event_flag;
        logic home_event_irq_enable;
        logic index_event_flag;
        logic index_event_irq_enable;
    } qec_stat_type;

    // Encoder pins, bit order {home, index, phase B, phase A}.
    typedef struct packed {
        logic home_input;
        logic index_input;
        logic phase_b_input;
        logic phase_a_input;
    } qec_pins_type;

    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } qec_avs_req_type;

    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [4:0] sync3;
        logic [4:0] stable;
        logic [6:0] filter_div;
        logic [3:0] filter_val;
        logic [3:0][1:0] filter_cnt;
        logic [6:0] presc_div;
        qec_ctrl_type ctrl;
        qec_ioc_type ioc;
        qec_stat_type stat;
        logic [31:0] position_counter;
        logic [31:0] init_capture_value;
        logic [31:0] greater_compare_value;
        logic [31:0] lesser_compare_value;
        logic [15:0] velocity;
        logic [31:0] index_count;
        logic [31:0] interval_timer;
        logic prev_a;
        logic prev_b;
        logic prev_index;
        logic prev_home;
        logic load_armed;
        logic home_seen;
        logic index_once;
        logic ack;
        logic [31:0] rdata;
        logic compare_pin;
        logic irq;
    } qec_state_type;

endpackage

`default_nettype wire

/* File: tb/qec_quadrature_encoder_control_chk.sv */
`include "qec_map.svh"
`default_nettype none
module qec_chk
    import qec_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire qec_avs_req_type i_avs,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire qec_pins_type i_enc,
    input wire logic i_ext_gate,
    input wire logic i_idle_mode,
    input wire logic o_compare_output_pin,
    input wire logic o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] fn_r;
    logic [15:0] rd;
    logic rdone;
    assign rd = o_avs_readdata[15:0];
    assign rdone = i_avs.read && !o_avs_waitrequest;
    // Shadow of the compare function, so the pin is judged without a bus read.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            fn_r <= 2'h0;
        end else if (i_avs.write && !o_avs_waitrequest && i_avs.byteenable[1]
            && i_avs.address == `QEC_OFS_IOC) begin
            fn_r <= i_avs.writedata[10:9];
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    reset_outputs_a: assert property ($fell(i_rst) |-> o_avs_waitrequest
        && !o_irq && !o_compare_output_pin) else $error("outputs not idle after reset");
    answer_next_a: assert property ((i_avs.read || i_avs.write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("bus request not answered");
    wait_one_cycle_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    no_unasked_a: assert property ($fell(o_avs_waitrequest)
        |-> $past(i_avs.read || i_avs.write)) else $error("answer without request");
    unmapped_zero_a: assert property (rdone && i_avs.address > 8'h24
        |-> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
    ctrl_rsvd_a: assert property (rdone && i_avs.address == `QEC_OFS_CTRL
        |-> o_avs_readdata[31:16] == 16'h0 && !rd[14] && !rd[7])
        else $error("control reserved bits set");
    stat_rsvd_a: assert property (rdone && i_avs.address == `QEC_OFS_STAT
        |-> o_avs_readdata[31:14] == 18'h0) else $error("status reserved bits set");
    irq_level_a: assert property (rdone && i_avs.address == `QEC_OFS_STAT
        |-> o_irq == |(rd[13:1] & rd[12:0] & 13'h1555)) else $error("irq mismatch");
    pin_off_a: assert property (fn_r == 2'h0 && $past(fn_r) == 2'h0
        |-> !o_compare_output_pin) else $error("compare pin high while off");
endmodule
bind qec_quadrature_encoder_control qec_chk qec_chk_inst (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_avs(i_avs), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_enc(i_enc), .i_ext_gate(i_ext_gate),
    .i_idle_mode(i_idle_mode), .o_compare_output_pin(o_compare_output_pin), .o_irq(o_irq));
`default_nettype wire

/* File: tb/qec_enc_model.sv */
`default_nettype none
module qec_enc_model
    import qec_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_step,
    input wire logic i_index,
    input wire logic i_home,
    output var qec_pins_type o_enc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] n = 2'h0;
    // Forward motion only: phase A leads phase B through a Gray sequence.
    always @(posedge i_clk_sys) begin
        if (i_step) begin
            n <= n + 2'h1;
        end
    end
    assign o_enc = {i_home, i_index, n[1], n[1] ^ n[0]};
endmodule
`default_nettype wire

/* File: tb/quadrature_encoder_control_tb.sv */
`include "qec_map.svh"
`default_nettype none
module quadrature_encoder_control_tb
    import qec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, step, idx, home, gate, idle, pin, irq, wreq;
    logic [31:0] rdata;
    qec_avs_req_type req;
    qec_pins_type enc;
    int n_fail = 0;
    int checks = 0;
    int ph = 0;
    qec_quadrature_encoder_control qec_quadrature_encoder_control_inst (.i_clk_sys(clk),
        .i_rst(rst), .i_avs(req), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_enc(enc), .i_ext_gate(gate), .i_idle_mode(idle), .o_compare_output_pin(pin),
        .o_irq(irq));
    qec_enc_model qec_enc_model_inst (.i_clk_sys(clk), .i_step(step), .i_index(idx),
        .i_home(home), .o_enc(enc));
    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{address: a, read: !w, write: w, writedata: d, byteenable: 4'hF};
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdata;
        req <= '0;
        if (n >= 50) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(nm, q, e);
    endtask
    task automatic steps(input int k);
        repeat (k) begin
            step <= 1'b1;
            @(posedge clk);
            step <= 1'b0;
            tick(8);
            ph = (ph + 1) % 4;
        end
    endtask
    task automatic pulse(input bit h);
        if (h) home <= 1'b1; else idx <= 1'b1;
        tick(12);
        home <= 1'b0;
        idx <= 1'b0;
        tick(12);
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        logic [31:0] q, v, e;
        logic [1:0] g;
        int p, k, fn;
        static logic [15:0] cf[6] = '{16'h8000, 16'h8400, 16'h8800, 16'h8C00, 16'h9000, 16'h8402};
        static int e1[6] = '{100, 0, 32'h1234, 32'h1234, 100, 100};
        static int e2[6] = '{100, 0, 32'h1234, 32'h1234, 32'h1234, 100};
        static int pv[3] = '{5, 15, 25};
        req = '0; rst = 1'b1; step = 1'b0; idx = 1'b0; home = 1'b0; gate = 1'b0; idle = 1'b0;
        p = $urandom(32'h28003800);
        tick(20);
        rst <= 1'b0;
        rchk("ctrl", `QEC_OFS_CTRL, 32'h0);
        rchk("ioc", `QEC_OFS_IOC, 32'h0);
        rchk("stat", `QEC_OFS_STAT, 32'h2800);
        rchk("unmapped", 8'h40, 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = $urandom & 32'h7FFF;
            wr(`QEC_OFS_CTRL, v);
            rchk("ctrl rw", `QEC_OFS_CTRL, v & `QEC_CTRL_WMASK);
            wr(`QEC_OFS_IOC, v);
            bus(1'b0, `QEC_OFS_IOC, 32'h0, q);
            check("ioc rw", q & `QEC_IOC_WMASK, v & `QEC_IOC_WMASK);
        end
        wr(`QEC_OFS_CTRL, 32'h0);
        $display("register test done");
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            home <= v[0];
            idx <= v[1];
            steps(v[3:2]);
            wr(`QEC_OFS_IOC, {v[8:4], 4'h0});
            tick(10);
            g = ph[1:0];
            e = {v[0] ^ v[7], v[1] ^ v[6], g[1] ^ v[5], g[1] ^ g[0] ^ v[4]};
            if (v[8]) e[1:0] = {e[0], e[1]};
            bus(1'b0, `QEC_OFS_IOC, 32'h0, q);
            check("pin status", q[3:0], e[3:0]);
        end
        wr(`QEC_OFS_IOC, 32'h0);
        home <= 1'b0;
        idx <= 1'b0;
        $display("polarity test done");
        e = 32'hFFFFFFFE;
        wr(`QEC_OFS_POS, e);
        for (int i = 0; i < 5; i++) begin
            idle <= (i == 3);
            gate <= (i == 4);
            wr(`QEC_OFS_CTRL, cf[0] | (i == 1 ? 16'h8 : 16'h0) | (i > 2 ? 16'h2004 : 16'h0));
            if (i == 2) wr(`QEC_OFS_CTRL, 32'h0);
            k = 3 + $urandom % 5;
            steps(k);
            e = e + (i == 1 ? -k : (i == 0 || i == 4) ? k : 0);
            rchk("position", `QEC_OFS_POS, e);
            if (i == 0) begin
                bus(1'b0, `QEC_OFS_STAT, 32'h0, q);
                check("overflow", q[9], 1'b1);
            end
        end
        idle <= 1'b0;
        wr(`QEC_OFS_CTRL, 32'h0);
        $display("count test done");
        wr(`QEC_OFS_GT_CMP, 32'd10);
        wr(`QEC_OFS_LT_CMP, 32'd20);
        for (int i = 0; i < 3; i++) begin
            wr(`QEC_OFS_POS, pv[i]);
            for (fn = 0; fn < 4; fn++) begin
                wr(`QEC_OFS_IOC, fn << 9);
                tick(3);
                e = (fn == 1) ? pv[i] >= 10 : (fn == 2) ? pv[i] <= 20 : fn == 3 && pv[i] == 15;
                check("compare pin", pin, e[0]);
            end
            wr(`QEC_OFS_STAT, 32'h0);
            tick(2);
            bus(1'b0, `QEC_OFS_STAT, 32'h0, q);
            check("compare flags", {q[13], q[11]}, {pv[i] >= 10, pv[i] <= 20});
        end
        wr(`QEC_OFS_STAT, 32'h1000);
        tick(3);
        check("irq on", irq, 1'b1);
        wr(`QEC_OFS_STAT, 32'h0);
        tick(3);
        check("irq off", irq, 1'b0);
        $display("compare test done");
        wr(`QEC_OFS_IOC, 32'h0);
        wr(`QEC_OFS_INIT_CAP, 32'h1234);
        g = ph[1:0];
        for (int m = 0; m < 6; m++) begin
            wr(`QEC_OFS_POS, 32'd100);
            wr(`QEC_OFS_CTRL, cf[m] | {g[1], g[1] ^ g[0], 8'h0});
            wr(`QEC_OFS_STAT, 32'h0);
            if (m == 3 || m == 4) pulse(1'b1);
            pulse(1'b0);
            rchk("first index", `QEC_OFS_POS, e1[m]);
            pulse(1'b0);
            rchk("second index", `QEC_OFS_POS, e2[m]);
            bus(1'b0, `QEC_OFS_STAT, 32'h0, q);
            e = (m == 3 || m == 4);
            check("event flags", {q[7], q[3], q[1]}, {e[0], e[0], 1'b1});
        end
        $display("index test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
